/* File: hdl/wcu_pkg.sv */
// Package of constants and types for the wrap counter unit
package wcu_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] WCU_OFS_STATUS = 8'h00;
  localparam logic [7:0] WCU_OFS_CLKCFG = 8'h04;
  localparam logic [7:0] WCU_OFS_COUNT = 8'h08;
  localparam logic [7:0] WCU_OFS_LIMIT = 8'h0C;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int WCU_SC_FLAG = 7;
  localparam int WCU_SC_IRQ_EN = 6;
  localparam int WCU_SC_CLEAR = 5;
  localparam int WCU_SC_HALT = 4;
  localparam int WCU_CK_SRC_LO = 4;
  localparam int WCU_CK_PS_LO = 0;

  // ****************************************
  // Reset values and limits
  // ****************************************
  localparam logic [7:0] WCU_CNT_RESET = 8'h00;
  localparam logic [7:0] WCU_LIM_RESET = 8'h00;
  localparam logic [3:0] WCU_PS_RESET = 4'h0;
  localparam logic WCU_HALT_RESET = 1'b1;
  localparam logic [3:0] WCU_PS_MAX = 4'h8;
  localparam logic [7:0] WCU_FREE_TOP = 8'hFF;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    WCU_SRC_BUS = 2'h0,
    WCU_SRC_FIXED = 2'h1,
    WCU_SRC_FALL = 2'h2,
    WCU_SRC_RISE = 2'h3
  } wcu_src_t;

  typedef enum logic [1:0] {
    WCU_AWAKE = 2'h0,
    WCU_LIGHT = 2'h1,
    WCU_DEEP = 2'h2,
    WCU_DEEPEST = 2'h3
  } wcu_sleep_t;

  typedef struct packed {
    logic irq_en;
    logic halt;
    wcu_src_t src;
    logic [3:0] ps;
  } wcu_cfg_t;

  localparam wcu_cfg_t WCU_CFG_RESET = '{1'b0, WCU_HALT_RESET, WCU_SRC_BUS, WCU_PS_RESET};

endpackage

/* File: hdl/wcu_prescaler.sv */
// Clock source selector and prescaler of the wrap counter unit
`timescale 1ns/1ps
`default_nettype none
module wcu_prescaler (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic restart,
  input wire wcu_pkg::wcu_src_t src,
  input wire logic [3:0] ps,
  input wire logic ext_clk,
  input wire logic fixed_clk,
  output logic tick
);

  logic ext_s1_r;
  logic ext_s2_r;
  logic ext_s3_r;
  logic fixed_d_r;
  logic [7:0] pre_r;
  logic src_edge;

  // Codes above eight saturate at divide by 256
  function automatic logic [7:0] ps_mask(input logic [3:0] code);
    logic [3:0] eff;
    logic [8:0] m;
    eff = (code > wcu_pkg::WCU_PS_MAX) ? wcu_pkg::WCU_PS_MAX : code;
    m = (9'h001 << eff) - 9'h001;
    return m[7:0];
  endfunction

  // ****************************************
  // External clock synchroniser
  // ****************************************
  // Edge detect reads stages two and three only, never the first flop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_s3_r <= 1'b0;
    end else begin
      ext_s1_r <= ext_clk;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fixed_d_r <= 1'b0;
    end else begin
      fixed_d_r <= fixed_clk;
    end
  end

  // ****************************************
  // Source edge select
  // ****************************************
  always_comb begin
    unique case (src)
      wcu_pkg::WCU_SRC_BUS: src_edge = 1'b1;
      wcu_pkg::WCU_SRC_FIXED: src_edge = fixed_clk & ~fixed_d_r;
      wcu_pkg::WCU_SRC_FALL: src_edge = ext_s3_r & ~ext_s2_r;
      wcu_pkg::WCU_SRC_RISE: src_edge = ~ext_s3_r & ext_s2_r;
    endcase
  end

  // ****************************************
  // Prescale divider
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_r <= 8'h00;
    end else if (restart) begin
      pre_r <= 8'h00;
    end else if (run && src_edge) begin
      pre_r <= pre_r + 8'h01;
    end
  end

  assign tick = run & src_edge & ((pre_r & ps_mask(ps)) == ps_mask(ps));

endmodule
`default_nettype wire

/* File: hdl/wcu_top.sv */
// Top level of the wrap counter unit with its Wishbone register slave
`timescale 1ns/1ps
`default_nettype none
module wcu_top (
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic EXT_COUNT_CLOCK,
  input wire logic FIXED_FREQ_CLOCK,
  input wire wcu_pkg::wcu_sleep_t SLEEP_DEPTH,
  input wire logic DEBUG_ACTIVE,
  output logic WRAP_IRQ
);

  // ****************************************
  // Operating mode states
  // ****************************************
  typedef enum logic [1:0] {
    WCU_M_RUN = 2'b00,
    WCU_M_DEBUG = 2'b01,
    WCU_M_LIGHT = 2'b11,
    WCU_M_DEEP = 2'b10
  } wcu_mode_t;

  wcu_mode_t mode_r;
  wcu_mode_t mode_nxt;

  // ****************************************
  // Declarations
  // ****************************************
  logic ack_r;
  logic [31:0] dat_r;
  logic req;
  logic mapped;
  logic lane0;
  logic wr_status;
  logic wr_clkcfg;
  logic wr_limit;
  logic rd_status;
  logic clear_cmd;
  logic soft_rst;
  logic restart;
  logic count_en;
  logic tick;
  logic wrap;
  logic sw_flag_clear;
  wcu_pkg::wcu_cfg_t cfg_r;
  logic flag_r;
  logic arm_r;
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic [7:0] lim_r;
  logic [7:0] rd_mux;

  // Limit zero behaves as a free run that wraps after 0xFF
  function automatic logic [7:0] top_of(input logic [7:0] lim);
    return (lim == 8'h00) ? wcu_pkg::WCU_FREE_TOP : lim;
  endfunction

  // Byte address decode to one of the four register words
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    return adr == ofs;
  endfunction

  // ****************************************
  // Sleep and debug mode tracking
  // ****************************************
  // Sleep outranks debug; any sleep depth stops the count.
  always_comb begin
    unique case (SLEEP_DEPTH)
      wcu_pkg::WCU_DEEP: mode_nxt = WCU_M_DEEP;
      wcu_pkg::WCU_DEEPEST: mode_nxt = WCU_M_DEEP;
      wcu_pkg::WCU_LIGHT: mode_nxt = WCU_M_LIGHT;
      wcu_pkg::WCU_AWAKE: mode_nxt = DEBUG_ACTIVE ? WCU_M_DEBUG : WCU_M_RUN;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      mode_r <= WCU_M_RUN;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // Deep sleep loses state: leaving it rebuilds the reset state.
  // A light sleep ended by reset is handled by RESETN itself.
  assign soft_rst = (mode_r == WCU_M_DEEP) && (mode_nxt != WCU_M_DEEP);

  // Light sleep ended by an interrupt simply resumes with state intact
  assign count_en = (mode_r == WCU_M_RUN) && !cfg_r.halt;

  // ****************************************
  // Wishbone slave decode
  // ****************************************
  // One request per ack; ack drops the cycle after it is given.
  assign req = WB_CYC_I && WB_STB_I && !ack_r;
  assign lane0 = WB_SEL_I[0];
  assign mapped = hit(WB_ADR_I, wcu_pkg::WCU_OFS_STATUS)
               || hit(WB_ADR_I, wcu_pkg::WCU_OFS_CLKCFG)
               || hit(WB_ADR_I, wcu_pkg::WCU_OFS_COUNT)
               || hit(WB_ADR_I, wcu_pkg::WCU_OFS_LIMIT);

  assign wr_status = req && WB_WE_I && lane0 && hit(WB_ADR_I, wcu_pkg::WCU_OFS_STATUS);
  assign wr_clkcfg = req && WB_WE_I && lane0 && hit(WB_ADR_I, wcu_pkg::WCU_OFS_CLKCFG);
  assign wr_limit = req && WB_WE_I && lane0 && hit(WB_ADR_I, wcu_pkg::WCU_OFS_LIMIT);
  assign rd_status = req && !WB_WE_I && hit(WB_ADR_I, wcu_pkg::WCU_OFS_STATUS);

  // Writes to the count word fall through with no effect
  assign clear_cmd = wr_status && WB_DAT_I[wcu_pkg::WCU_SC_CLEAR];
  assign restart = clear_cmd || wr_limit || soft_rst;

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req;
    end
  end

  // ****************************************
  // Read data path
  // ****************************************
  // Unused and write-only bits read back as zero
  always_comb begin
    rd_mux = 8'h00;
    if (hit(WB_ADR_I, wcu_pkg::WCU_OFS_STATUS)) begin
      rd_mux[wcu_pkg::WCU_SC_FLAG] = flag_r;
      rd_mux[wcu_pkg::WCU_SC_IRQ_EN] = cfg_r.irq_en;
      rd_mux[wcu_pkg::WCU_SC_HALT] = cfg_r.halt;
    end else if (hit(WB_ADR_I, wcu_pkg::WCU_OFS_CLKCFG)) begin
      rd_mux[wcu_pkg::WCU_CK_SRC_LO +: 2] = cfg_r.src;
      rd_mux[wcu_pkg::WCU_CK_PS_LO +: 4] = cfg_r.ps;
    end else if (hit(WB_ADR_I, wcu_pkg::WCU_OFS_COUNT)) begin
      rd_mux = cnt_r;
    end else if (hit(WB_ADR_I, wcu_pkg::WCU_OFS_LIMIT)) begin
      rd_mux = lim_r;
    end
  end

  // Unmapped reads are acked with zero so the master never hangs
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      dat_r <= 32'h0000_0000;
    end else if (req && !WB_WE_I) begin
      dat_r <= mapped ? {24'h00_0000, rd_mux} : 32'h0000_0000;
    end
  end

  assign WB_DAT_O = dat_r;
  assign WB_ACK_O = ack_r;

  // ****************************************
  // Control fields
  // ****************************************
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      cfg_r <= wcu_pkg::WCU_CFG_RESET;
    end else if (soft_rst) begin
      cfg_r <= wcu_pkg::WCU_CFG_RESET;
    end else begin
      if (wr_status) begin
        cfg_r.irq_en <= WB_DAT_I[wcu_pkg::WCU_SC_IRQ_EN];
        cfg_r.halt <= WB_DAT_I[wcu_pkg::WCU_SC_HALT];
      end
      if (wr_clkcfg) begin
        // Source and divide change on the fly; the count is kept
        cfg_r.src <= wcu_pkg::wcu_src_t'(WB_DAT_I[wcu_pkg::WCU_CK_SRC_LO +: 2]);
        cfg_r.ps <= WB_DAT_I[wcu_pkg::WCU_CK_PS_LO +: 4];
      end
    end
  end

  // ****************************************
  // Wrap limit register
  // ****************************************
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      lim_r <= wcu_pkg::WCU_LIM_RESET;
    end else if (soft_rst) begin
      lim_r <= wcu_pkg::WCU_LIM_RESET;
    end else if (wr_limit) begin
      lim_r <= WB_DAT_I[7:0];
    end
  end

  // ****************************************
  // Clock source and prescaler
  // ****************************************
  // Prescaler restarts with the count so the first period is whole
  wcu_prescaler u_prescaler (
    .clk(SYS_CLK),
    .rst_n(RESETN),
    .run(count_en),
    .restart(restart),
    .src(cfg_r.src),
    .ps(cfg_r.ps),
    .ext_clk(EXT_COUNT_CLOCK),
    .fixed_clk(FIXED_FREQ_CLOCK),
    .tick(tick)
  );

  // ****************************************
  // Counter
  // ****************************************
  assign wrap = tick && (cnt_r == top_of(lim_r));
  assign cnt_nxt = wrap ? 8'h00 : cnt_r + 8'h01;

  // A clear or limit write wins over a tick in the same cycle
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      cnt_r <= wcu_pkg::WCU_CNT_RESET;
    end else if (restart) begin
      cnt_r <= wcu_pkg::WCU_CNT_RESET;
    end else if (tick) begin
      cnt_r <= cnt_nxt;
    end
  end

  // ****************************************
  // Wrap flag and its clear sequence
  // ****************************************
  // A status read that sees the flag set arms the clear.
  // Any status write consumes the arm, so a stale read never clears.
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      arm_r <= 1'b0;
    end else if (restart || wr_status) begin
      arm_r <= 1'b0;
    end else if (rd_status && flag_r) begin
      arm_r <= 1'b1;
    end
  end

  assign sw_flag_clear = wr_status && arm_r && !WB_DAT_I[wcu_pkg::WCU_SC_FLAG];

  // Priority: restart, then a new wrap, then the software clear
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      flag_r <= 1'b0;
    end else if (restart) begin
      flag_r <= 1'b0;
    end else if (wrap) begin
      flag_r <= 1'b1;
    end else if (sw_flag_clear) begin
      flag_r <= 1'b0;
    end
  end

  // ****************************************
  // Interrupt request
  // ****************************************
  // Level request; if software enables it with the flag pending,
  // the request fires at once, which is why the flag is cleared first.
  assign WRAP_IRQ = flag_r && cfg_r.irq_en;

endmodule
`default_nettype wire

/* File: verification/wcu_ext_src.sv */
// Model of the source that drives the external count clock pin
`timescale 1ns/1ps
`default_nettype none
module wcu_ext_src #(
  parameter int PERIOD = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic [9:0] n_per,
  output logic busy,
  output logic ext_clk
);
  // ****************************************
  // Burst of n_per full periods
  // ****************************************
  logic [9:0] left_r;
  int ph_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      left_r <= 10'h000;
      ph_r <= 0;
    end else if (go) begin
      left_r <= n_per;
      ph_r <= 0;
    end else if (left_r != 10'h000) begin
      ph_r <= (ph_r == PERIOD - 1) ? 0 : ph_r + 1;
      if (ph_r == PERIOD - 1)
        left_r <= left_r - 10'h001;
    end
  end
  // PERIOD of 4 or more bus cycles keeps every edge visible after sync
  assign ext_clk = (left_r != 10'h000) && (ph_r < PERIOD / 2);
  assign busy = left_r != 10'h000;
endmodule
`default_nettype wire

/* File: verification/wcu_top_properties.sv */
// Port-level assertions of the wrap counter unit
`timescale 1ns/1ps
`default_nettype none
module wcu_top_properties (
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  input wire logic EXT_COUNT_CLOCK,
  input wire logic FIXED_FREQ_CLOCK,
  input wire wcu_pkg::wcu_sleep_t SLEEP_DEPTH,
  input wire logic DEBUG_ACTIVE,
  input wire logic WRAP_IRQ
);
  // ****************************************
  // Checks
  // ****************************************
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);
  a_ack_next: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("access not acknowledged");
  a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (!(WB_CYC_I && WB_STB_I) |=> !WB_ACK_O)
    else $error("ack without request");
  a_status_zero_bits: assert property (WB_ACK_O && !$past(WB_WE_I) && $past(WB_ADR_I) == 8'h00
    |-> WB_DAT_O[5] == 1'b0 && WB_DAT_O[3:0] == 4'h0) else $error("status unused bits set");
  a_unmapped_zero: assert property (WB_ACK_O && !$past(WB_WE_I) && ($past(WB_ADR_I) & 8'hF3) != 8'h00
    |-> WB_DAT_O == 32'h0) else $error("unmapped read not zero");
  a_asleep_no_wrap: assert property ((SLEEP_DEPTH != wcu_pkg::WCU_AWAKE || DEBUG_ACTIVE)
    && !(WB_CYC_I && WB_STB_I && WB_WE_I) |=> !$rose(WRAP_IRQ)) else $error("wrap while held");
  a_deep_exit_reset: assert property ($past(SLEEP_DEPTH[1]) && !SLEEP_DEPTH[1] |=> !WRAP_IRQ)
    else $error("irq survives deep sleep exit");
  a_limit_clears: assert property (WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O && WB_SEL_I[0]
    && WB_ADR_I == 8'h0C |=> !WRAP_IRQ) else $error("limit write kept flag");
  a_clear_wins: assert property (WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O && WB_SEL_I[0]
    && WB_ADR_I == 8'h00 && WB_DAT_I[5] |=> !WRAP_IRQ) else $error("clear bit kept flag");
endmodule
bind wcu_top wcu_top_properties i_props (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
  .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .EXT_COUNT_CLOCK(EXT_COUNT_CLOCK),
  .FIXED_FREQ_CLOCK(FIXED_FREQ_CLOCK), .SLEEP_DEPTH(SLEEP_DEPTH), .DEBUG_ACTIVE(DEBUG_ACTIVE),
  .WRAP_IRQ(WRAP_IRQ));
`default_nettype wire

/* File: verification/wcu_top_test.sv */
// Self-checking testbench of the wrap counter unit
`timescale 1ns/1ps
`default_nettype none
module wcu_top_test;
  // ****************************************
  // Bench and device
  // ****************************************
  localparam logic [7:0] ST = wcu_pkg::WCU_OFS_STATUS;
  localparam logic [7:0] CK = wcu_pkg::WCU_OFS_CLKCFG;
  localparam logic [7:0] CN = wcu_pkg::WCU_OFS_COUNT;
  localparam logic [7:0] LM = wcu_pkg::WCU_OFS_LIMIT;
  logic clk, rst_n, cyc, stb, we, ack, ext, fix, dbg, irq, go, busy;
  logic [7:0] adr, q, a;
  logic [3:0] sel, sel_v;
  logic [9:0] n_per, e;
  logic [31:0] dat_i, dat_o;
  wcu_pkg::wcu_sleep_t sleep;
  int num_errors, tests_run, cycles;
  wcu_top i_dut (.SYS_CLK(clk), .RESETN(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
    .EXT_COUNT_CLOCK(ext), .FIXED_FREQ_CLOCK(fix), .SLEEP_DEPTH(sleep), .DEBUG_ACTIVE(dbg),
    .WRAP_IRQ(irq));
  wcu_ext_src #(.PERIOD(4)) i_src (.clk(clk), .rst_n(rst_n), .go(go), .n_per(n_per),
    .busy(busy), .ext_clk(ext));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  logic [1:0] fdiv;
  // Fixed clock toggles every four bus cycles, driven on the rising edge like all stimulus
  always @(posedge clk) begin
    fdiv <= fdiv + 2'h1;
    if (fdiv == 2'h3)
      fix <= ~fix;
  end
  // Twenty external bursts dominate the run, about 25000 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles > 40000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic ck_irq(input string nm, input logic exp);
    chk(nm, {7'h0, irq}, {7'h0, exp});
  endtask
  task automatic wb(input logic w, input logic [7:0] ad, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= ad;
    sel <= sel_v;
    dat_i <= {24'h0, d};
    do
      @(posedge clk);
    while (ack !== 1'b1 && n++ < 20);
    chk("ack", {7'h0, ack}, 8'h01);
    q = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    wb(1'b1, ad, d);
  endtask
  task automatic rd(input string nm, input logic [7:0] ad, input logic [7:0] exp);
    wb(1'b0, ad, 8'h00);
    chk(nm, q, exp);
  endtask
  task automatic frozen(input string nm);
    repeat (4) @(posedge clk);
    wb(1'b0, CN, 8'h00);
    a = q;
    wb(1'b0, CN, 8'h00);
    chk(nm, q, a);
  endtask
  // Clear, select, run one burst of 300 periods, then halt
  task automatic run_ext(input logic [1:0] s, input logic [3:0] p);
    wr(ST, 8'h30);
    wr(CK, {2'b00, s, p});
    wr(ST, 8'h00);
    @(posedge clk);
    n_per <= 10'd300;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 2000 && busy !== 1'b0; i++)
      @(posedge clk);
    repeat (8) @(posedge clk);
    wr(ST, 8'h10);
  endtask
  task automatic done(input string nm);
    $display("test %s done", nm);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    rst_n = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'hF;
    sel_v = 4'hF;
    dat_i = 32'h0;
    fix = 1'b0;
    fdiv = 2'h0;
    dbg = 1'b0;
    go = 1'b0;
    n_per = 10'h000;
    sleep = wcu_pkg::WCU_AWAKE;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd("status rst", ST, 8'h10);
    rd("clkcfg rst", CK, 8'h00);
    rd("count rst", CN, 8'h00);
    rd("limit rst", LM, 8'h00);
    wr(8'h10, 8'hFF);
    rd("unmapped", 8'h10, 8'h00);
    wr(CN, 8'h55);
    rd("count ro", CN, 8'h00);
    done("reset");
    for (int s = 2; s < 4; s++) begin
      for (int p = 0; p < 10; p++) begin
        run_ext(s[1:0], p[3:0]);
        e = 10'd300 >> ((p > 8) ? 8 : p);
        ck_irq("masked", 1'b0);
        rd("ext count", CN, e[7:0]);
        rd("flag", ST, {e[8], 7'h10});
        // Pending flag is cleared before the enable is set
        wr(ST, 8'h10);
        wr(ST, 8'h50);
        ck_irq("irq", 1'b0);
        wr(ST, 8'h50);
        ck_irq("irq off", 1'b0);
        rd("flag off", ST, 8'h50);
      end
    end
    done("external");
    wr(LM, 8'h03);
    wr(CK, 8'h00);
    wr(ST, 8'h40);
    for (int i = 0; i < 3; i++) begin
      wb(1'b0, CN, 8'h00);
      chk("bound", {7'h0, q <= 8'h03}, 8'h01);
    end
    wr(ST, 8'h50);
    ck_irq("wrap irq", 1'b1);
    sel_v = 4'hE;
    wr(LM, 8'hAA);
    sel_v = 4'hF;
    ck_irq("sel ignored", 1'b1);
    wr(LM, 8'h03);
    ck_irq("limit clr", 1'b0);
    rd("limit", LM, 8'h03);
    rd("limit cnt", CN, 8'h00);
    wr(ST, 8'h40);
    repeat (10) @(posedge clk);
    wr(ST, 8'h50);
    ck_irq("rewrap", 1'b1);
    wr(ST, 8'h70);
    ck_irq("clr bit", 1'b0);
    rd("clr reads", ST, 8'h50);
    rd("clr cnt", CN, 8'h00);
    done("limit");
    wr(LM, 8'h00);
    wr(ST, 8'h30);
    wr(CK, 8'h10);
    wr(ST, 8'h00);
    repeat (80) @(posedge clk);
    wr(ST, 8'h10);
    wb(1'b0, CN, 8'h00);
    chk("fixed", {7'h0, q >= 8'h08 && q <= 8'h0C}, 8'h01);
    wr(CK, 8'h00);
    wr(ST, 8'h00);
    @(posedge clk);
    dbg <= 1'b1;
    frozen("debug");
    @(posedge clk);
    dbg <= 1'b0;
    sleep <= wcu_pkg::WCU_LIGHT;
    frozen("light");
    @(posedge clk);
    sleep <= wcu_pkg::WCU_AWAKE;
    repeat (4) @(posedge clk);
    wb(1'b0, CN, 8'h00);
    chk("resume", {7'h0, q != a}, 8'h01);
    wr(LM, 8'h07);
    @(posedge clk);
    sleep <= wcu_pkg::WCU_DEEP;
    frozen("deep");
    @(posedge clk);
    sleep <= wcu_pkg::WCU_DEEPEST;
    @(posedge clk);
    sleep <= wcu_pkg::WCU_AWAKE;
    rd("deep st", ST, 8'h10);
    rd("deep lim", LM, 8'h00);
    rd("deep cnt", CN, 8'h00);
    done("sleep");
    tally_and_finish();
  end
endmodule
`default_nettype wire
